// ===== mct_pkg.sv
// Package of constants and types for the match capture timer
package mct_pkg;
    // Register byte offsets
    localparam logic [7:0] MCT_OFF_CTRL = 8'h00;
    localparam logic [7:0] MCT_OFF_COUNT = 8'h04;
    localparam logic [7:0] MCT_OFF_PRESCALE = 8'h08;
    localparam logic [7:0] MCT_OFF_PRECOUNT = 8'h0c;
    localparam logic [7:0] MCT_OFF_MATCHCTL = 8'h10;
    localparam logic [7:0] MCT_OFF_MATCH0 = 8'h14;
    localparam logic [7:0] MCT_OFF_CAPCTL = 8'h24;
    localparam logic [7:0] MCT_OFF_CAPVAL = 8'h28;
    localparam logic [7:0] MCT_OFF_EXTCTL = 8'h2c;
    localparam logic [7:0] MCT_OFF_PWMCTL = 8'h30;
    localparam logic [7:0] MCT_OFF_STATUS = 8'h34;
    localparam logic [7:0] MCT_OFF_MASK = 8'h38;
    // Control fields
    localparam int MCT_CTRL_EN_BIT = 0;
    localparam int MCT_CTRL_RST_BIT = 1;
    // Match control: per channel 3 bits {stop, reset, irq}
    localparam int MCT_MC_IRQ = 0;
    localparam int MCT_MC_RST = 1;
    localparam int MCT_MC_STOP = 2;
    localparam int MCT_MC_W = 3;
    // Capture control fields
    localparam int MCT_CAP_RISE_BIT = 0;
    localparam int MCT_CAP_FALL_BIT = 1;
    // Status bits: 0..3 match, 4 capture
    localparam int MCT_ST_CAP_BIT = 4;
    localparam int MCT_ST_W = 5;
    localparam int MCT_NMATCH = 4;
    localparam int MCT_NEXT = 2;
    localparam logic [31:0] MCT_RST_VAL = 32'h0000_0000;

    // External output action on match
    typedef enum logic [1:0] {
        MCT_ACT_NONE = 2'b00,
        MCT_ACT_LOW = 2'b01,
        MCT_ACT_HIGH = 2'b10,
        MCT_ACT_TOGGLE = 2'b11
    } mct_act_t;

    // Slave side of the APB bus
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } mct_apb_req_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } mct_apb_rsp_t;
endpackage

// ===== mct_sync.sv
// Two-flop synchroniser for a pin input
`timescale 1ns/100ps
module mct_sync
    import mct_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic din,
    output logic dout
);
    logic meta_q;
    logic sync_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end
        else
        begin
            meta_q <= din;
            sync_q <= meta_q;
        end
    end

    assign dout = sync_q;
endmodule // mct_sync

// ===== mct_edge.sv
// Selectable edge detector on a synchronised level
`timescale 1ns/100ps
module mct_edge
    import mct_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic level,
    input wire logic on_rise,
    input wire logic on_fall,
    output logic hit
);
    logic prev_q;
    logic prev_d;

    always_comb
    begin
        prev_d = level;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prev_q <= 1'b0;
        end
        else
        begin
            prev_q <= prev_d;
        end
    end

    assign hit = (on_rise && level && !prev_q) || (on_fall && !level && prev_q);
endmodule // mct_edge

// ===== mct_timer.sv
// Match capture timer with prescaler, four matches, one capture and APB registers
//
// The address map and register access over APB were decided locally.
`timescale 1ns/100ps
module mct_timer
    import mct_pkg::*;
#(
    parameter int WIDTH = 32
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cap_in,
    output logic [MCT_NEXT-1:0] match_out,
    output logic irq
);
    mct_apb_req_t req;
    mct_apb_rsp_t rsp;
    logic wr;
    logic [WIDTH-1:0] count_q, count_d;
    logic [WIDTH-1:0] pre_q, pre_d;
    logic [WIDTH-1:0] prescale_q, prescale_d;
    logic [WIDTH-1:0] match_q [MCT_NMATCH];
    logic [WIDTH-1:0] match_d [MCT_NMATCH];
    logic [MCT_NMATCH*MCT_MC_W-1:0] mctl_q, mctl_d;
    logic [1:0] ctrl_q, ctrl_d;
    logic [1:0] capctl_q, capctl_d;
    logic [2*MCT_NEXT-1:0] extctl_q, extctl_d;
    logic [MCT_NEXT-1:0] pwm_q, pwm_d;
    logic [MCT_NEXT-1:0] ext_q, ext_d;
    logic [WIDTH-1:0] cap_q, cap_d;
    logic [MCT_ST_W-1:0] stat_q, stat_d;
    logic [MCT_ST_W-1:0] mask_q, mask_d;
    logic [MCT_NMATCH-1:0] hit;
    logic tick;
    logic cap_sync;
    logic cap_hit;
    logic [31:0] rdata_d;
    logic [31:0] rdata_q;

    assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};
    assign wr = req.psel && req.penable && req.pwrite;

    // Capture pin path
    mct_sync u_sync (.pclk(pclk), .presetn(presetn), .din(cap_in), .dout(cap_sync));
    mct_edge u_edge (.pclk(pclk), .presetn(presetn), .level(cap_sync),
        .on_rise(capctl_q[MCT_CAP_RISE_BIT]), .on_fall(capctl_q[MCT_CAP_FALL_BIT]),
        .hit(cap_hit));

    // Prescaler tick, one-cycle enable
    assign tick = ctrl_q[MCT_CTRL_EN_BIT] && !ctrl_q[MCT_CTRL_RST_BIT]
        && (pre_q == prescale_q);

    // Match compare on the count at each counter step
    genvar g;
    generate
        for (g = 0; g < MCT_NMATCH; g++)
        begin : g_cmp
            assign hit[g] = tick && (count_q == match_q[g]);
        end
    endgenerate

    // Counter and prescaler
    always_comb
    begin
        pre_d = pre_q;
        count_d = count_q;
        ctrl_d = ctrl_q;
        if (ctrl_q[MCT_CTRL_RST_BIT])
        begin
            pre_d = '0;
            count_d = '0;
        end
        else if (ctrl_q[MCT_CTRL_EN_BIT])
        begin
            if (tick)
            begin
                pre_d = '0;
                count_d = count_q + 1'b1;
            end
            else
            begin
                pre_d = pre_q + 1'b1;
            end
        end
        for (int i = 0; i < MCT_NMATCH; i++)
        begin
            if (hit[i] && mctl_q[i*MCT_MC_W+MCT_MC_RST])
            begin
                count_d = '0;
            end
            if (hit[i] && mctl_q[i*MCT_MC_W+MCT_MC_STOP])
            begin
                ctrl_d[MCT_CTRL_EN_BIT] = 1'b0;
            end
        end
        if (wr && req.paddr == MCT_OFF_CTRL)
        begin
            ctrl_d = req.pwdata[1:0];
        end
        if (wr && req.paddr == MCT_OFF_COUNT)
        begin
            count_d = req.pwdata[WIDTH-1:0];
        end
        if (wr && req.paddr == MCT_OFF_PRECOUNT)
        begin
            pre_d = req.pwdata[WIDTH-1:0];
        end
    end

    // Configuration registers
    always_comb
    begin
        prescale_d = prescale_q;
        mctl_d = mctl_q;
        capctl_d = capctl_q;
        extctl_d = extctl_q;
        pwm_d = pwm_q;
        mask_d = mask_q;
        for (int i = 0; i < MCT_NMATCH; i++)
        begin
            match_d[i] = match_q[i];
            if (wr && req.paddr == MCT_OFF_MATCH0 + 8'(4 * i))
            begin
                match_d[i] = req.pwdata[WIDTH-1:0];
            end
        end
        if (wr)
        begin
            unique case (req.paddr)
                MCT_OFF_PRESCALE: prescale_d = req.pwdata[WIDTH-1:0];
                MCT_OFF_MATCHCTL: mctl_d = req.pwdata[MCT_NMATCH*MCT_MC_W-1:0];
                MCT_OFF_CAPCTL: capctl_d = req.pwdata[1:0];
                MCT_OFF_EXTCTL: extctl_d = req.pwdata[2*MCT_NEXT-1:0];
                MCT_OFF_PWMCTL: pwm_d = req.pwdata[MCT_NEXT-1:0];
                MCT_OFF_MASK: mask_d = req.pwdata[MCT_ST_W-1:0];
                default: ;
            endcase
        end
    end

    // Capture, status and external outputs
    always_comb
    begin
        cap_d = cap_q;
        if (cap_hit)
        begin
            cap_d = count_q;
        end
        stat_d = stat_q;
        if (wr && req.paddr == MCT_OFF_STATUS)
        begin
            stat_d = stat_q & ~req.pwdata[MCT_ST_W-1:0];
        end
        for (int i = 0; i < MCT_NMATCH; i++)
        begin
            if (hit[i] && mctl_q[i*MCT_MC_W+MCT_MC_IRQ])
            begin
                stat_d[i] = 1'b1;
            end
        end
        if (cap_hit)
        begin
            stat_d[MCT_ST_CAP_BIT] = 1'b1;
        end
        ext_d = ext_q;
        for (int i = 0; i < MCT_NEXT; i++)
        begin
            if (pwm_q[i])
            begin
                // PWM: low from counter reset, high once count reaches match
                if (count_d == '0)
                begin
                    ext_d[i] = 1'b0;
                end
                else if (count_d >= match_q[i])
                begin
                    ext_d[i] = 1'b1;
                end
            end
            else if (hit[i])
            begin
                unique case (mct_act_t'(extctl_q[2*i +: 2]))
                    MCT_ACT_NONE: ext_d[i] = ext_q[i];
                    MCT_ACT_LOW: ext_d[i] = 1'b0;
                    MCT_ACT_HIGH: ext_d[i] = 1'b1;
                    MCT_ACT_TOGGLE: ext_d[i] = ~ext_q[i];
                endcase
            end
        end
    end

    // Read mux
    always_comb
    begin
        rdata_d = 32'h0000_0000;
        for (int i = 0; i < MCT_NMATCH; i++)
        begin
            if (req.paddr == MCT_OFF_MATCH0 + 8'(4 * i))
            begin
                rdata_d[WIDTH-1:0] = match_q[i];
            end
        end
        unique case (req.paddr)
            MCT_OFF_CTRL: rdata_d[1:0] = ctrl_q;
            MCT_OFF_COUNT: rdata_d[WIDTH-1:0] = count_q;
            MCT_OFF_PRESCALE: rdata_d[WIDTH-1:0] = prescale_q;
            MCT_OFF_PRECOUNT: rdata_d[WIDTH-1:0] = pre_q;
            MCT_OFF_MATCHCTL: rdata_d[MCT_NMATCH*MCT_MC_W-1:0] = mctl_q;
            MCT_OFF_CAPCTL: rdata_d[1:0] = capctl_q;
            MCT_OFF_CAPVAL: rdata_d[WIDTH-1:0] = cap_q;
            MCT_OFF_EXTCTL: rdata_d[2*MCT_NEXT-1:0] = extctl_q;
            MCT_OFF_PWMCTL: rdata_d[MCT_NEXT-1:0] = pwm_q;
            MCT_OFF_STATUS: rdata_d[MCT_ST_W-1:0] = stat_q;
            MCT_OFF_MASK: rdata_d[MCT_ST_W-1:0] = mask_q;
            default: ;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            count_q <= MCT_RST_VAL[WIDTH-1:0];
            pre_q <= MCT_RST_VAL[WIDTH-1:0];
            prescale_q <= MCT_RST_VAL[WIDTH-1:0];
            for (int i = 0; i < MCT_NMATCH; i++)
            begin
                match_q[i] <= MCT_RST_VAL[WIDTH-1:0];
            end
            mctl_q <= '0;
            ctrl_q <= 2'h0;
            capctl_q <= 2'h0;
            extctl_q <= '0;
            pwm_q <= '0;
            ext_q <= '0;
            cap_q <= MCT_RST_VAL[WIDTH-1:0];
            stat_q <= '0;
            mask_q <= '0;
            rdata_q <= 32'h0000_0000;
        end
        else
        begin
            count_q <= count_d;
            pre_q <= pre_d;
            prescale_q <= prescale_d;
            for (int i = 0; i < MCT_NMATCH; i++)
            begin
                match_q[i] <= match_d[i];
            end
            mctl_q <= mctl_d;
            ctrl_q <= ctrl_d;
            capctl_q <= capctl_d;
            extctl_q <= extctl_d;
            pwm_q <= pwm_d;
            ext_q <= ext_d;
            cap_q <= cap_d;
            stat_q <= stat_d;
            mask_q <= mask_d;
            rdata_q <= rdata_d;
        end
    end

    // Read data registered in setup phase, answered in the access phase
    assign rsp = '{pready: 1'b1, pslverr: 1'b0, prdata: rdata_q};
    assign pready = rsp.pready;
    assign pslverr = rsp.pslverr;
    assign prdata = rsp.prdata;
    assign match_out = ext_q;
    assign irq = |(stat_q & mask_q);

    a_reset_clears: assert property (@(posedge pclk) disable iff (!presetn)
        hit[0] && mctl_q[MCT_MC_RST] && !ctrl_q[MCT_CTRL_RST_BIT] && !wr |=> count_q == '0)
        else $error("Count not cleared on match");
    a_stop_halts: assert property (@(posedge pclk) disable iff (!presetn)
        hit[2] && mctl_q[2*MCT_MC_W+MCT_MC_STOP] && !wr |=> !ctrl_q[MCT_CTRL_EN_BIT])
        else $error("Counter not stopped on match");
    a_match_flag: assert property (@(posedge pclk) disable iff (!presetn)
        hit[2] && mctl_q[2*MCT_MC_W+MCT_MC_IRQ] |=> stat_q[2])
        else $error("Match flag not set");
    a_count_step: assert property (@(posedge pclk) disable iff (!presetn)
        tick && mctl_q == '0 && !wr |=> count_q == $past(count_q) + 1'b1 && pre_q == '0)
        else $error("Counter did not step on prescale");
    a_idle_hold: assert property (@(posedge pclk) disable iff (!presetn)
        !ctrl_q[MCT_CTRL_EN_BIT] && !ctrl_q[MCT_CTRL_RST_BIT] && !wr |=> $stable(count_q))
        else $error("Count moved while disabled");
    a_cap_copy: assert property (@(posedge pclk) disable iff (!presetn)
        cap_hit |=> cap_q == $past(count_q) && stat_q[MCT_ST_CAP_BIT])
        else $error("Capture missed");
    a_toggle_out: assert property (@(posedge pclk) disable iff (!presetn)
        hit[0] && !pwm_q[0] && extctl_q[1:0] == 2'b11 |=> match_out[0] != $past(match_out[0]))
        else $error("Output did not toggle");
    a_pwm_low: assert property (@(posedge pclk) disable iff (!presetn)
        pwm_q[1] && count_d == '0 |=> !match_out[1])
        else $error("PWM output not low at period start");
    a_cap_sync: assert property (@(posedge pclk) disable iff (!presetn)
        cap_hit && capctl_q == 2'b01 |-> cap_sync && !$past(cap_sync))
        else $error("Capture on wrong edge");
endmodule // mct_timer

// ===== mct_pin_model.sv
// Pin-side model: drives the capture pin, watches the match outputs
`timescale 1ns/100ps
module mct_pin_model
    import mct_pkg::*;
(
    input wire logic pclk,
    input wire logic clr,
    input wire logic cap_level,
    input wire logic [MCT_NEXT-1:0] match_out,
    output logic cap_in,
    output int edges0,
    output int highs1
);
    logic last0;

    // Pin level follows the request; the device synchronises it
    assign cap_in = cap_level;

    always @(posedge pclk)
    begin
        last0 <= match_out[0];
        if (clr)
        begin
            edges0 <= 0;
            highs1 <= 0;
        end
        else
        begin
            edges0 <= edges0 + int'(match_out[0] !== last0);
            highs1 <= highs1 + int'(match_out[1] === 1'b1);
        end
    end
endmodule // mct_pin_model

// ===== match_capture_timer_tb_top.sv
// Self-checking bench of the match capture timer
`timescale 1ns/100ps
`define CHK(n, e, g) \
    begin num_checks++; if ((g) !== (e)) begin bad_count++; \
    $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module match_capture_timer_tb_top
    import mct_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic [31:0] prdata_w;
    logic [31:0] rw;
    logic pready;
    logic pslverr;
    logic cap_in;
    logic cap_level = 1'b0;
    logic clr = 1'b1;
    logic [MCT_NEXT-1:0] match_out;
    logic irq;
    logic [31:0] r;
    logic [31:0] c0;
    int edges0;
    int highs1;
    int bad_count = 0;
    int num_checks = 0;

    always #2.5 pclk = ~pclk;

    mct_timer #(.WIDTH(16)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .cap_in(cap_in),
        .match_out(match_out), .irq(irq));

    mct_pin_model pins (.pclk(pclk), .clr(clr), .cap_level(cap_level),
        .match_out(match_out), .cap_in(cap_in), .edges0(edges0), .highs1(highs1));

    // Wide variant on the same bus, only its read data is watched
    mct_timer #(.WIDTH(32)) dut_wide (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata_w), .pready(), .pslverr(), .cap_in(cap_in),
        .match_out(), .irq());

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        r = prdata;
        rw = prdata_w;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0000_0000);
    endtask

    task automatic restart(input logic [31:0] ps);
        wr(MCT_OFF_CTRL, 32'h0000_0002);
        wr(MCT_OFF_PRESCALE, ps);
        wr(MCT_OFF_CTRL, 32'h0000_0001);
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic t_reset_width();
        rd(MCT_OFF_COUNT);
        `CHK("count", 32'h0000_0000, r)
        `CHK("irq", 1'b0, irq)
        wr(MCT_OFF_PRESCALE, 32'hffff_ffff);
        rd(MCT_OFF_PRESCALE);
        `CHK("prescale", 32'h0000_ffff, r)
        `CHK("prescale wide", 32'hffff_ffff, rw)
        wr(8'h3c, 32'h0000_00ff);
        rd(8'h3c);
        `CHK("unmapped", 32'h0000_0000, r)
        `CHK("slverr", 1'b0, pslverr)
        $display("test reset_width done");
    endtask

    task automatic t_prescale();
        restart(32'h0000_0003);
        rd(MCT_OFF_COUNT);
        c0 = r;
        repeat (37) @(posedge pclk);
        rd(MCT_OFF_COUNT);
        `CHK("steps", 32'd10, r - c0)
        $display("test prescale done");
    endtask

    task automatic t_wrap_irq();
        wr(MCT_OFF_MATCH0, 32'd5);
        wr(MCT_OFF_MATCH0 + 8'h04, 32'd2);
        wr(MCT_OFF_MATCH0 + 8'h0c, 32'd4);
        wr(MCT_OFF_MATCHCTL, 32'h0000_000b);
        restart(32'h0000_0000);
        rd(MCT_OFF_COUNT);
        c0 = r;
        repeat (37) @(posedge pclk);
        rd(MCT_OFF_COUNT);
        `CHK("wrap", 32'd4, (r + 32'd6 - c0) % 32'd6)
        rd(MCT_OFF_STATUS);
        `CHK("status", 32'h0000_0003, r)
        $display("test wrap_irq done");
    endtask

    task automatic t_outputs();
        wr(MCT_OFF_EXTCTL, {30'd0, MCT_ACT_HIGH});
        repeat (12) @(posedge pclk);
        `CHK("out high", 1'b1, match_out[0])
        wr(MCT_OFF_EXTCTL, {30'd0, MCT_ACT_LOW});
        repeat (12) @(posedge pclk);
        `CHK("out low", 1'b0, match_out[0])
        foreach (c0[i])
        begin
            if (i < 2)
            begin
                wr(MCT_OFF_EXTCTL, (i == 0) ? {30'd0, MCT_ACT_TOGGLE} : {30'd0, MCT_ACT_NONE});
                clr <= 1'b0;
                repeat (24) @(posedge pclk);
                clr <= 1'b1;
                `CHK("toggles", (i == 0) ? 4 : 0, edges0)
            end
        end
        $display("test outputs done");
    endtask

    task automatic t_pwm();
        wr(MCT_OFF_MATCHCTL, 32'h0000_0400);
        wr(MCT_OFF_MATCH0 + 8'h0c, 32'd7);
        wr(MCT_OFF_MATCH0 + 8'h04, 32'd3);
        wr(MCT_OFF_PWMCTL, 32'h0000_0002);
        restart(32'h0000_0000);
        repeat (20) @(posedge pclk);
        clr <= 1'b0;
        // The pin model lags one edge, so 81 edges give 80 samples
        repeat (81) @(posedge pclk);
        clr <= 1'b1;
        `CHK("pwm high", 50, highs1)
        $display("test pwm done");
    endtask

    task automatic t_stop_mask();
        wr(MCT_OFF_STATUS, 32'h0000_001f);
        wr(MCT_OFF_MATCH0 + 8'h08, 32'd6);
        wr(MCT_OFF_MATCHCTL, 32'h0000_01c0);
        restart(32'h0000_0000);
        repeat (20) @(posedge pclk);
        rd(MCT_OFF_CTRL);
        `CHK("stop en", 1'b0, r[MCT_CTRL_EN_BIT])
        rd(MCT_OFF_COUNT);
        c0 = r;
        repeat (10) @(posedge pclk);
        rd(MCT_OFF_COUNT);
        `CHK("halted", c0, r)
        wr(MCT_OFF_MASK, 32'h0000_0004);
        // Let the mask write settle before looking at irq
        @(negedge pclk);
        `CHK("irq on", 1'b1, irq)
        wr(MCT_OFF_MASK, 32'h0000_0001);
        @(negedge pclk);
        `CHK("irq masked", 1'b0, irq)
        wr(MCT_OFF_MASK, 32'h0000_0004);
        wr(MCT_OFF_STATUS, 32'h0000_0004);
        rd(MCT_OFF_STATUS);
        `CHK("w1c", 32'h0000_0000, r)
        `CHK("irq off", 1'b0, irq)
        $display("test stop_mask done");
    endtask

    task automatic t_capture();
        // Counter is halted, so a known count waits for the capture
        wr(MCT_OFF_COUNT, 32'h0000_1234);
        wr(MCT_OFF_MASK, 32'h0000_0010);
        wr(MCT_OFF_CAPCTL, 32'h0000_0002);
        cap_level <= 1'b1;
        repeat (8) @(posedge pclk);
        `CHK("rise ignored", 1'b0, irq)
        cap_level <= 1'b0;
        repeat (8) @(posedge pclk);
        `CHK("fall irq", 1'b1, irq)
        rd(MCT_OFF_CAPVAL);
        `CHK("capval", 32'h0000_1234, r)
        wr(MCT_OFF_STATUS, 32'h0000_0010);
        wr(MCT_OFF_CAPCTL, 32'h0000_0001);
        cap_level <= 1'b1;
        repeat (8) @(posedge pclk);
        `CHK("rise irq", 1'b1, irq)
        wr(MCT_OFF_STATUS, 32'h0000_0010);
        wr(MCT_OFF_CAPCTL, 32'h0000_0003);
        cap_level <= 1'b0;
        repeat (8) @(posedge pclk);
        `CHK("both irq", 1'b1, irq)
        $display("test capture done");
    endtask

    initial
    begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_reset_width();
        t_prescale();
        t_wrap_irq();
        t_outputs();
        t_pwm();
        t_stop_mask();
        t_capture();
        test_done();
    end

    initial
    begin
        repeat (20000) @(posedge pclk);
        bad_count++;
        test_done();
    end
endmodule // match_capture_timer_tb_top
